// File: src/sas_top.sv
`timescale 1ns/1ps
module sas_top
    import sas_pkg::*;
#(
    parameter int unsigned ACK_CYC  = 32'(SAS_ACK_CYC),
    parameter int unsigned AUTO_CYC = 32'(SAS_AUTO_CYC)
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire sas_fault_t  fault_in,
    input  wire logic        key_on_pin,
    input  wire logic        mode_btn_pin,
    input  wire logic        override_req,
    output sas_ind_t         ind,
    output logic [19:0]      disp_spn,
    output logic [4:0]       disp_fmi,
    output logic             log_valid,
    output logic             log_override,
    output logic [19:0]      log_spn,
    output logic [4:0]       log_fmi
);
    ////////////////////////////////////////////////////////////////////////////
    logic [2:0]  key_sync;
    logic [2:0]  btn_sync;
    logic        key_q;
    logic        btn_q;
    logic        key_off_ev;
    logic        key_on_ev;
    logic [31:0] slot [SAS_SLOTS];
    logic [7:0]  cust_en;
    logic [2:0]  slot_cnt;
    logic [SAS_SLOTS-1:0] hit;
    logic [SAS_SLOTS-1:0] slot_act;
    logic        any_act;
    logic        rise;
    logic [19:0] hit_spn;
    logic [4:0]  hit_fmi;
    logic        latched;
    logic        acked;
    logic        overridden;
    logic        ack_ev;
    logic [31:0] btn_cnt;
    logic [31:0] auto_cnt;
    logic        any_act_q;
    logic        wr;
    logic        rd;
    logic [15:0] log_cnt;

    // inputs from pins: a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_sync <= 3'h0;
            btn_sync <= 3'h0;
            key_q    <= 1'b0;
            btn_q    <= 1'b0;
        end else begin
            key_sync <= {key_sync[1:0], key_on_pin};
            btn_sync <= {btn_sync[1:0], mode_btn_pin};
            if (key_sync[1] == key_sync[2]) begin
                key_q <= key_sync[2];
            end
            if (btn_sync[1] == btn_sync[2]) begin
                btn_q <= btn_sync[2];
            end
        end
    end

    logic key_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_prev <= 1'b0;
        end else begin
            key_prev <= key_q;
        end
    end
    assign key_off_ev = key_prev & ~key_q;
    assign key_on_ev  = ~key_prev & key_q;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < SAS_SLOTS; i++) begin
                slot[i] <= SAS_SLOT_RST;
            end
            cust_en  <= 8'h00;
            slot_cnt <= 3'h0;
        end else if (wr) begin
            if (paddr == SAS_CTRL_OFF) begin
                slot_cnt <= (pwdata[3:0] > 4'(SAS_SLOTS)) ? 3'(SAS_SLOTS) : pwdata[2:0];
            end else if (paddr == SAS_CUST_OFF) begin
                cust_en <= pwdata[7:0];
            end else if (paddr >= SAS_SLOT_OFF && paddr < SAS_SLOT_OFF + 8'(4 * SAS_SLOTS)
                         && paddr[1:0] == 2'h0) begin
                for (int i = 0; i < SAS_SLOTS; i++) begin
                    if (paddr == SAS_SLOT_OFF + 8'(4 * i)) begin
                        slot[i][19:0] <= (pwdata[19:0] > SAS_SPN_MAX) ? SAS_SPN_MAX : pwdata[19:0];
                        slot[i][31:20] <= {1'b0, pwdata[30:20]};
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (rd) begin
                if (paddr == SAS_CTRL_OFF) begin
                    prdata <= {29'h0, slot_cnt};
                end else if (paddr == SAS_STAT_OFF) begin
                    // [13:8] slot_act, [7:6] spare, [5:0] flags
                    prdata <= {18'h0, slot_act, 2'h0, overridden, acked, latched, any_act,
                               ind.start_ok, ind.run};
                end else if (paddr == SAS_ALM_OFF) begin
                    prdata <= {7'h0, disp_fmi, disp_spn};
                end else if (paddr == SAS_LOG_OFF) begin
                    prdata <= {16'h0, log_cnt};
                end else if (paddr == SAS_CUST_OFF) begin
                    prdata <= {24'h0, cust_en};
                end else if (paddr >= SAS_SLOT_OFF && paddr < SAS_SLOT_OFF + 8'(4 * SAS_SLOTS)) begin
                    prdata <= slot[3'((paddr - SAS_SLOT_OFF) >> 2)];
                end else begin
                    prdata <= 32'h0;
                end
            end
            if (psel & ~penable) begin
                pslverr <= (paddr[1:0] != 2'h0) || (paddr > SAS_CUST_OFF);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // slot matching, one comparator per slot
    genvar g;
    generate
        for (g = 0; g < SAS_SLOTS; g++) begin : g_slot
            logic en_ok;
            assign en_ok = slot[g][SAS_EN_POS] && (g < slot_cnt)
                && (!slot[g][SAS_CUS_POS] || cust_en[slot[g][SAS_CIX_POS +: 3]]);
            assign hit[g] = fault_in.valid && en_ok
                && (fault_in.custom == slot[g][SAS_CUS_POS])
                && (fault_in.spn == slot[g][19:0])
                && (slot[g][SAS_ANY_POS] || fault_in.fmi == slot[g][24:20]);
        end
    endgenerate

    // slot goes active on a match and inactive when its report stops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_act <= '0;
        end else begin
            slot_act <= hit;
        end
    end
    assign any_act = |slot_act;
    assign rise    = |(hit & ~slot_act);

    always_comb begin
        hit_spn = 20'h0;
        hit_fmi = 5'h0;
        for (int i = SAS_SLOTS - 1; i >= 0; i--) begin
            if (hit[i] && !slot_act[i]) begin
                hit_spn = fault_in.spn;
                hit_fmi = fault_in.fmi;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // acknowledge: long press or one minute of continuous popup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_cnt  <= 32'h0;
            auto_cnt <= 32'h0;
            ack_ev   <= 1'b0;
        end else begin
            ack_ev <= 1'b0;
            if (!btn_q) begin
                btn_cnt <= 32'h0;
            end else if (btn_cnt <= ACK_CYC) begin
                btn_cnt <= btn_cnt + 32'h1;
                if (btn_cnt == ACK_CYC) begin
                    ack_ev <= 1'b1;
                end
            end
            if (!ind.popup || ack_ev) begin
                auto_cnt <= 32'h0;
            end else if (auto_cnt == AUTO_CYC - 1) begin
                auto_cnt <= 32'h0;
                ack_ev   <= 1'b1;
            end else begin
                auto_cnt <= auto_cnt + 32'h1;
            end
        end
    end

    // latched: an alarm exists that still inhibits start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched    <= 1'b0;
            acked      <= 1'b0;
            overridden <= 1'b0;
            disp_spn   <= 20'h0;
            disp_fmi   <= 5'h0;
        end else begin
            if (rise) begin
                latched  <= 1'b1;
                acked    <= 1'b0;
                disp_spn <= hit_spn;
                disp_fmi <= hit_fmi;
            end else if (ack_ev && latched) begin
                acked <= 1'b1;
            end
            if (key_off_ev) begin
                overridden <= 1'b0;
            end else if (override_req && latched && key_q && !overridden) begin
                overridden <= 1'b1;
            end
            if (key_on_ev && !rise) begin
                if (any_act && acked) begin
                    acked <= 1'b0;
                end else if (!any_act && acked) begin
                    latched <= 1'b0;
                end
                // unacknowledged and cleared stays latched until acknowledged and keyed on again
            end
            if (!rise && !any_act && acked && !key_on_ev && !key_q) begin
                latched <= latched;
            end
        end
    end

    // start inhibit lifts only via key cycle clear or override; ack alone never releases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind <= '0;
        end else begin
            ind.popup      <= latched && !acked && !rise;
            ind.red        <= latched && (!acked || any_act);
            ind.buzzer     <= latched && !acked && (any_act || !any_act_q) && !rise;
            ind.check_lamp <= latched;
            ind.stop_lamp  <= latched;
            ind.start_ok   <= !latched || overridden;
            ind.run        <= key_q && (!latched || overridden) && !rise;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            any_act_q <= 1'b0;
        end else if (rise) begin
            any_act_q <= 1'b0;
        end else if (!any_act && latched && !acked) begin
            any_act_q <= 1'b1;
        end else if (key_on_ev) begin
            any_act_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault log strobe; override entries carry the displayed alarm
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            log_valid    <= 1'b0;
            log_override <= 1'b0;
            log_spn      <= 20'h0;
            log_fmi      <= 5'h0;
            log_cnt      <= 16'h0;
        end else begin
            log_valid    <= 1'b0;
            log_override <= 1'b0;
            if (rise) begin
                log_valid <= 1'b1;
                log_spn   <= hit_spn;
                log_fmi   <= hit_fmi;
                log_cnt   <= log_cnt + 16'h1;
            end else if (override_req && latched && key_q && !overridden && !key_off_ev) begin
                log_valid    <= 1'b1;
                log_override <= 1'b1;
                log_spn      <= disp_spn;
                log_fmi      <= disp_fmi;
                log_cnt      <= log_cnt + 16'h1;
            end
        end
    end
endmodule : sas_top

// File: src/sas_pkg.sv
package sas_pkg;
    localparam int          SAS_SLOTS      = 6;
    localparam logic [19:0] SAS_SPN_MAX    = 20'd599999;
    localparam logic [7:0]  SAS_APB_AW     = 8'hff;
    // register byte offsets
    localparam logic [7:0]  SAS_CTRL_OFF   = 8'h00;
    localparam logic [7:0]  SAS_STAT_OFF   = 8'h04;
    localparam logic [7:0]  SAS_ALM_OFF    = 8'h08;
    localparam logic [7:0]  SAS_LOG_OFF    = 8'h0c;
    localparam logic [7:0]  SAS_SLOT_OFF   = 8'h10;
    localparam logic [7:0]  SAS_CUST_OFF   = 8'h30;
    // slot word: [19:0] spn, [24:20] fmi, [25] any, [26] enable, [27] custom, [30:28] custom index
    localparam int          SAS_FMI_POS    = 20;
    localparam int          SAS_ANY_POS    = 25;
    localparam int          SAS_EN_POS     = 26;
    localparam int          SAS_CUS_POS    = 27;
    localparam int          SAS_CIX_POS    = 28;
    localparam logic [31:0] SAS_SLOT_RST   = 32'h0000_0000;
    // timing at 40 mhz
    localparam longint      SAS_CLK_HZ     = 40000000;
    localparam longint      SAS_ACK_MS     = 1000;
    localparam longint      SAS_AUTO_MS    = 60000;
    localparam longint      SAS_ACK_CYC    = SAS_CLK_HZ / 1000 * SAS_ACK_MS;
    localparam longint      SAS_AUTO_CYC   = SAS_CLK_HZ / 1000 * SAS_AUTO_MS;

    typedef struct packed {
        logic        valid;
        logic        custom;
        logic [19:0] spn;
        logic [4:0]  fmi;
    } sas_fault_t;

    typedef struct packed {
        logic        run;
        logic        popup;
        logic        red;
        logic        buzzer;
        logic        check_lamp;
        logic        stop_lamp;
        logic        start_ok;
    } sas_ind_t;
endpackage : sas_pkg

// File: sim/sas_assertions.sv
`timescale 1ns/1ps
module sas_assertions
    import sas_pkg::*;
#(
    parameter int unsigned ACK_CYC  = 20,
    parameter int unsigned AUTO_CYC = 100
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        mode_btn_pin,
    input wire sas_ind_t    ind,
    input wire logic [19:0] disp_spn,
    input wire logic [4:0]  disp_fmi,
    input wire logic        log_valid,
    input wire logic        log_override,
    input wire logic [19:0] log_spn,
    input wire logic [4:0]  log_fmi
);
    int unsigned pop_cnt;
    int unsigned btn_cnt;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // long holds are counted here; a repetition that long would choke the tools
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pop_cnt <= 0;
        end else begin
            pop_cnt <= ind.popup ? pop_cnt + 1 : 0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_cnt <= 0;
        end else begin
            btn_cnt <= mode_btn_pin ? btn_cnt + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////
    popup_red_a: assert property (ind.popup |-> ind.red)
        else $error("popup shown without red");
    popup_stop_a: assert property (ind.popup |-> !ind.run)
        else $error("engine runs under popup");
    popup_inhibit_a: assert property (ind.popup |-> !ind.start_ok)
        else $error("start allowed under popup");
    log_pulse_a: assert property (log_valid |=> !log_valid)
        else $error("log strobe longer than one cycle");
    override_log_a: assert property (log_override |-> log_valid)
        else $error("override flag without log strobe");
    log_disp_a: assert property (log_valid && !log_override |-> ##[0:2]
        (disp_spn == log_spn && disp_fmi == log_fmi))
        else $error("display differs from logged alarm");
    ack_keeps_a: assert property ($fell(ind.popup) && ind.stop_lamp |-> ind.red && ind.check_lamp)
        else $error("lamps dropped on acknowledge");
    auto_ack_a: assert property (pop_cnt <= AUTO_CYC + 4)
        else $error("popup outlived auto acknowledge");
    button_ack_a: assert property (btn_cnt > ACK_CYC + 10 |-> !ind.popup)
        else $error("long button hold did not acknowledge");
endmodule : sas_assertions

bind sas_top sas_assertions #(
    .ACK_CYC (ACK_CYC),
    .AUTO_CYC(AUTO_CYC)
) i_sas_assertions (
    .pclk        (pclk),
    .presetn     (presetn),
    .mode_btn_pin(mode_btn_pin),
    .ind         (ind),
    .disp_spn    (disp_spn),
    .disp_fmi    (disp_fmi),
    .log_valid   (log_valid),
    .log_override(log_override),
    .log_spn     (log_spn),
    .log_fmi     (log_fmi)
);

// File: sim/sas_ecu_model.sv
`timescale 1ns/1ps
module sas_ecu_model
    import sas_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        send,
    input  wire logic        custom,
    input  wire logic [19:0] spn,
    input  wire logic [4:0]  fmi,
    output sas_fault_t       fault_in
);
    // between reports the fields are scrambled so nothing leans on stale values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_in <= '0;
        end else if (send) begin
            fault_in <= {1'b1, custom, spn, fmi};
        end else begin
            fault_in <= {1'b0, ~fault_in.custom, ~fault_in.spn, ~fault_in.fmi};
        end
    end
endmodule : sas_ecu_model

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sas_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] r;
        logic        e;
    } sas_row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        key_on_pin, mode_btn_pin, override_req, send, custom;
    logic        log_valid, log_override;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [19:0] spn, disp_spn, log_spn;
    logic [4:0]  fmi, disp_fmi, log_fmi;
    sas_fault_t  fault_in;
    sas_ind_t    ind;
    int          n_fail, n_checks;
    sas_row_t    rows [6] = '{
        '{8'h00, 32'h0000_0007, 32'h0000_0006, 1'b0},
        '{8'h00, 32'h0000_0003, 32'h0000_0003, 1'b0},
        '{8'h10, 32'h05f9_27bf, 32'h05f9_27bf, 1'b0},
        '{8'h14, 32'h0009_27c0, 32'h0009_27bf, 1'b0},
        '{8'h40, 32'hffff_ffff, 32'h0000_0000, 1'b1},
        '{8'h02, 32'hffff_ffff, 32'h0000_0000, 1'b1}
    };

    sas_top #(.ACK_CYC(20), .AUTO_CYC(100)) i_sas_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .fault_in, .key_on_pin, .mode_btn_pin, .override_req, .ind, .disp_spn, .disp_fmi,
        .log_valid, .log_override, .log_spn, .log_fmi);
    sas_ecu_model i_sas_ecu_model (.pclk, .presetn, .send, .custom, .spn, .fmi, .fault_in);

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // entered just after a rising edge; the idle edge at the end keeps drivers apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look mid-cycle so the answer is read while it stands, then close on the rising edge
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_log(input logic ovr, input logic [19:0] s, input logic [4:0] f);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (log_valid !== 1'b1 && n < 40);
        chk(log_valid, 1);
        chk(log_override, ovr);
        if (!ovr) begin
            chk({log_fmi, log_spn}, {f, s});
        end
        @(posedge pclk);
    endtask : wait_log
    task automatic report(input logic c, input logic [19:0] s, input logic [4:0] f);
        send <= 1'b1;
        custom <= c;
        spn <= s;
        fmi <= f;
    endtask : report
    task automatic key_cycle;
        key_on_pin <= 1'b0;
        repeat (10) @(posedge pclk);
        key_on_pin <= 1'b1;
        repeat (10) @(posedge pclk);
    endtask : key_cycle
    task automatic press(input int n);
        mode_btn_pin <= 1'b1;
        repeat (n) @(posedge pclk);
        mode_btn_pin <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : press
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 20000);
        n_fail++;
        print_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {key_on_pin, mode_btn_pin, override_req, send, custom, spn, fmi} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(ind, 0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, SAS_SLOT_OFF + 8'(4 * i), 32'h0);
            chk(rd, SAS_SLOT_RST);
        end
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0);
            chk({rd, err}, {rows[i].r, rows[i].e});
        end
        key_on_pin <= 1'b1;
        apb(1'b1, SAS_SLOT_OFF, 32'h0000_006e);
        apb(1'b1, 8'h18, 32'h0c00_0000);
        report(1'b0, 20'd110, 5'd0);
        repeat (15) @(posedge pclk);
        chk(ind.popup, 0);
        report(1'b1, 20'd0, 5'd0);
        repeat (15) @(posedge pclk);
        chk(ind.popup, 0);
        send <= 1'b0;
        apb(1'b1, SAS_SLOT_OFF, 32'h0600_006e);
        report(1'b0, 20'd110, 5'd7);
        wait_log(1'b0, 20'd110, 5'd7);
        repeat (3) @(posedge pclk);
        chk({ind.popup, ind.red, ind.run, ind.start_ok, disp_fmi, disp_spn}, {4'b1100, 25'h070006e});
        press(10);
        chk(ind.popup, 1);
        press(40);
        chk({ind.popup, ind.red, ind.check_lamp, ind.stop_lamp, ind.start_ok}, 5'b01110);
        override_req <= 1'b1;
        @(posedge pclk);
        override_req <= 1'b0;
        wait_log(1'b1, 20'd0, 5'd0);
        repeat (3) @(posedge pclk);
        chk(ind.start_ok, 1);
        key_cycle();
        chk({ind.popup, ind.start_ok}, 2'b10);
        repeat (60) @(posedge pclk);
        chk(ind.popup, 1);
        repeat (60) @(posedge pclk);
        chk(ind.popup, 0);
        send <= 1'b0;
        repeat (5) @(posedge pclk);
        key_cycle();
        chk({ind.popup, ind.start_ok}, 2'b01);
        apb(1'b1, 8'h14, 32'h0430_00c8);
        report(1'b0, 20'd200, 5'd3);
        wait_log(1'b0, 20'd200, 5'd3);
        send <= 1'b0;
        repeat (5) @(posedge pclk);
        key_cycle();
        chk({ind.popup, ind.start_ok}, 2'b10);
        print_verdict();
    end
endmodule : tb_top
